/* File: eof_consts.vh */
// constants for the operand format and alignment block
// assumes a 32-bit ahb-lite register bus and one core clock
`ifndef EOF_CONSTS_VH
`define EOF_CONSTS_VH

// register byte offsets
`define EOF_OFF_CTRL 8'h00
`define EOF_OFF_BASE 8'h04
`define EOF_OFF_STATUS 8'h08
`define EOF_OFF_IMM 8'h0c
`define EOF_OFF_VEC0 8'h10
`define EOF_OFF_VEC3 8'h1c
`define EOF_OFF_FLT0 8'h20
`define EOF_OFF_FLT3 8'h2c
`define EOF_OFF_TSTATE 8'h30
`define EOF_OFF_EXCPTR 8'h34
`define EOF_OFF_TCMD 8'h38
`define EOF_OFF_IP 8'h3c
`define EOF_OFF_CHKADDR 8'h40
`define EOF_OFF_SAVEDIP 8'h44

// operand type codes
`define EOF_TY_UD 4'h0
`define EOF_TY_D 4'h1
`define EOF_TY_UW 4'h2
`define EOF_TY_W 4'h3
`define EOF_TY_UB 4'h4
`define EOF_TY_B 4'h5
`define EOF_TY_F 4'h6
`define EOF_TY_HALF 4'h7
`define EOF_TY_QW 4'h8
`define EOF_TY_DQ 4'h9
`define EOF_TY_QQ 4'ha

// control register fields
`define EOF_CTRL_TYPE_LSB 0
`define EOF_CTRL_IDX_LSB 8
`define EOF_CTRL_RESET 32'h0000_0000

// status bits
`define EOF_ST_ALIGN 0
`define EOF_ST_HALF 1
`define EOF_ST_LASTOK 2
`define EOF_ST_ACTIVE 3
`define EOF_ST_EXC 4

// thread command bits
`define EOF_CMD_DISPATCH 0
`define EOF_CMD_SEND 1
`define EOF_CMD_END 2
`define EOF_CMD_EXC 3
`define EOF_CMD_SLOT_LSB 4

// thread state fields
`define EOF_TS_SLOT_LSB 0
`define EOF_TS_UNIT_LSB 2
`define EOF_TS_MASK_LSB 8

// instruction step in bytes
`define EOF_INSTR_BYTES 32'h0000_0010

`endif

/* File: eof_vf_expand.v */
// one restricted 8-bit float to single precision
// assumes a purely combinational use by the owning block
`timescale 1ns/1ps
module eof_vf_expand (
  tinyFloat,
  singleFloat
);
  input wire [7:0] tinyFloat;
  output wire [31:0] singleFloat;

  wire sign;
  wire [2:0] exp3;
  wire [3:0] frac;
  wire isZero;
  wire [7:0] exp8;

  assign sign = tinyFloat[7];
  assign exp3 = tinyFloat[6:4];
  assign frac = tinyFloat[3:0];
  // implied one even at exponent zero, so only zero exponent and fraction is zero, either sign
  assign isZero = (exp3 == 3'h0) && (frac == 4'h0);
  // bias 3 to 127: top bit copied, then five inverted copies of it, low two bits kept
  assign exp8 = {exp3[2], {5{~exp3[2]}}, exp3[1:0]};
  assign singleFloat = isZero ? {sign, 31'h0000_0000} : {sign, exp8, frac, 19'h00000};
endmodule

/* File: eof_top.v */
// operand format, alignment check and thread state block
// assumes an ahb-lite master on ref_clk and core side signals on the same clock
//
// Local design decisions: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "eof_consts.vh"

module eof_top #(
  parameter MASK_WIDTH = 8
) (
  ref_clk,
  resetn,
  hsel,
  haddr,
  htrans,
  hwrite,
  hsize,
  hready,
  hwdata,
  hreadyout,
  hrdata,
  hresp,
  unitLocation,
  dispatcherMask,
  exceptionHandlerPointer,
  instrRetire,
  accessOk,
  accessErr,
  checkedAddr,
  threadActive,
  threadEnded,
  jumpValid,
  jumpTarget
);
  input wire ref_clk;
  input wire resetn;
  input wire hsel;
  input wire [31:0] haddr;
  input wire [1:0] htrans;
  input wire hwrite;
  input wire [2:0] hsize;
  input wire hready;
  input wire [31:0] hwdata;
  output wire hreadyout;
  output reg [31:0] hrdata;
  output wire hresp;
  input wire [3:0] unitLocation;
  input wire [MASK_WIDTH-1:0] dispatcherMask;
  input wire [31:0] exceptionHandlerPointer;
  input wire instrRetire;
  output reg accessOk;
  output reg accessErr;
  output reg [31:0] checkedAddr;
  output reg threadActive;
  output reg threadEnded;
  output reg jumpValid;
  output reg [31:0] jumpTarget;

  //////////////////////////////////////////////////////////////////////////////
  // bus slave: zero wait states, read data registered in the address phase
  // hsize is not decoded: only whole-word transfers are expected here

  reg wrPend_reg;
  reg [7:0] wrAddr_reg;
  reg [31:0] ctrl_reg;
  reg [31:0] base_reg;
  reg [31:0] imm_reg;
  reg [31:0] ip_reg;
  reg [31:0] savedIp_reg;
  reg [1:0] slot_reg;
  reg [3:0] unit_reg;
  reg [3:0] unitSync1_reg;
  reg [3:0] unitSync2_reg;
  reg checkPend_reg;
  reg alignErr_reg;
  reg halfErr_reg;
  reg lastOk_reg;
  reg excSeen_reg;
  reg [31:0] rdData_next;
  wire addrPhase;
  wire wrStrobe;
  wire [31:0] statusWord;
  wire [31:0] threadState;

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign addrPhase = hsel && hready && htrans[1];
  assign wrStrobe = wrPend_reg && hready;

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wrPend_reg <= 1'b0;
      wrAddr_reg <= 8'h00;
      hrdata <= 32'h0000_0000;
    end else begin
      if (hready) begin
        wrPend_reg <= addrPhase && hwrite;
        wrAddr_reg <= haddr[7:0];
      end
      if (addrPhase && !hwrite) begin
        hrdata <= rdData_next;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // packed immediate vectors
  // both views are decoded live from the one stored immediate

  wire [127:0] wordVec;
  wire [127:0] floatVec;
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi = gi + 1) begin : g_int
      // element gi sits at bits 4gi+3..4gi, lowest element rightmost
      assign wordVec[16*gi +: 16] = {{12{imm_reg[4*gi+3]}}, imm_reg[4*gi +: 4]};
    end
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_flt
      eof_vf_expand u_vf (
        .tinyFloat(imm_reg[8*gi +: 8]),
        .singleFloat(floatVec[32*gi +: 32])
      );
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////////
  // register read mux

  assign statusWord = {27'h0000000, excSeen_reg, threadActive, lastOk_reg,
                       halfErr_reg, alignErr_reg};
  // read-only view of the thread identity and mask
  assign threadState = {{(24-MASK_WIDTH){1'b0}}, dispatcherMask, 2'b00, unit_reg,
                        slot_reg};

  // unmapped offsets and the write-only command word read as zero
  always @* begin
    rdData_next = 32'h0000_0000;
    case (haddr[7:0])
      `EOF_OFF_CTRL: rdData_next = ctrl_reg;
      `EOF_OFF_BASE: rdData_next = base_reg;
      `EOF_OFF_STATUS: rdData_next = statusWord;
      `EOF_OFF_IMM: rdData_next = imm_reg;
      8'h10: rdData_next = wordVec[31:0];
      8'h14: rdData_next = wordVec[63:32];
      8'h18: rdData_next = wordVec[95:64];
      `EOF_OFF_VEC3: rdData_next = wordVec[127:96];
      `EOF_OFF_FLT0: rdData_next = floatVec[31:0];
      8'h24: rdData_next = floatVec[63:32];
      8'h28: rdData_next = floatVec[95:64];
      `EOF_OFF_FLT3: rdData_next = floatVec[127:96];
      `EOF_OFF_TSTATE: rdData_next = threadState;
      `EOF_OFF_EXCPTR: rdData_next = exceptionHandlerPointer;
      `EOF_OFF_IP: rdData_next = ip_reg;
      `EOF_OFF_CHKADDR: rdData_next = checkedAddr;
      `EOF_OFF_SAVEDIP: rdData_next = savedIp_reg;
      default: rdData_next = 32'h0000_0000;
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // element size decode and alignment check

  reg [2:0] sizeLog;
  reg typeValid;
  wire [3:0] typeCode;
  wire [7:0] elemIndex;
  wire [31:0] elemOffset;
  wire [31:0] elemAddr;
  wire [31:0] alignMask;
  wire isHalf;
  wire misaligned;
  wire checkNow;

  assign typeCode = ctrl_reg[`EOF_CTRL_TYPE_LSB +: 4];
  assign elemIndex = ctrl_reg[`EOF_CTRL_IDX_LSB +: 8];

  always @* begin
    sizeLog = 3'h0;
    typeValid = 1'b1;
    case (typeCode)
      `EOF_TY_UB, `EOF_TY_B: sizeLog = 3'h0;
      `EOF_TY_UW, `EOF_TY_W: sizeLog = 3'h1;
      `EOF_TY_UD, `EOF_TY_D, `EOF_TY_F: sizeLog = 3'h2;
      `EOF_TY_QW: sizeLog = 3'h3;
      `EOF_TY_DQ: sizeLog = 3'h4;
      `EOF_TY_QQ: sizeLog = 3'h5;
      default: typeValid = 1'b0;
    endcase
  end

  // element 0 sits at the region origin, higher ones step leftward
  assign elemOffset = {24'h000000, elemIndex} << sizeLog;
  assign elemAddr = base_reg + elemOffset;
  assign alignMask = ~(32'hffff_ffff << sizeLog);
  assign isHalf = (typeCode == `EOF_TY_HALF);
  assign misaligned = ((elemAddr & alignMask) != 32'h0000_0000) || !typeValid;
  assign checkNow = wrStrobe && (wrAddr_reg == `EOF_OFF_BASE);

  //////////////////////////////////////////////////////////////////////////////
  // configuration registers and check results

  wire clrStatus;
  assign clrStatus = wrStrobe && (wrAddr_reg == `EOF_OFF_STATUS);

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= `EOF_CTRL_RESET;
      base_reg <= 32'h0000_0000;
      imm_reg <= 32'h0000_0000;
      checkedAddr <= 32'h0000_0000;
      accessOk <= 1'b0;
      accessErr <= 1'b0;
      alignErr_reg <= 1'b0;
      halfErr_reg <= 1'b0;
      lastOk_reg <= 1'b0;
    end else begin
      accessOk <= 1'b0;
      accessErr <= 1'b0;
      if (wrStrobe && (wrAddr_reg == `EOF_OFF_CTRL)) begin
        ctrl_reg <= {16'h0000, hwdata[15:0]};
      end
      if (wrStrobe && (wrAddr_reg == `EOF_OFF_IMM)) begin
        imm_reg <= hwdata;
      end
      if (checkNow) begin
        base_reg <= hwdata;
      end
      // write one to clear, a same-cycle new error wins
      if (clrStatus && hwdata[`EOF_ST_ALIGN]) begin
        alignErr_reg <= 1'b0;
      end
      if (clrStatus && hwdata[`EOF_ST_HALF]) begin
        halfErr_reg <= 1'b0;
      end
      if (checkPend_reg) begin
        checkedAddr <= elemAddr;
        if (isHalf) begin
          halfErr_reg <= 1'b1;
          accessErr <= 1'b1;
          lastOk_reg <= 1'b0;
        end else if (misaligned) begin
          alignErr_reg <= 1'b1;
          accessErr <= 1'b1;
          lastOk_reg <= 1'b0;
        end else begin
          accessOk <= 1'b1;
          lastOk_reg <= 1'b1;
        end
      end
    end
  end

  // check runs the cycle after the base write, on the stored address
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      checkPend_reg <= 1'b0;
    end else begin
      checkPend_reg <= checkNow;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // thread life cycle and exception jump

  wire cmdWrite;
  wire doDispatch;
  wire doEnd;
  wire doExc;

  assign cmdWrite = wrStrobe && (wrAddr_reg == `EOF_OFF_TCMD);
  assign doDispatch = cmdWrite && hwdata[`EOF_CMD_DISPATCH] && !threadActive;
  assign doEnd = cmdWrite && hwdata[`EOF_CMD_SEND] && hwdata[`EOF_CMD_END] &&
                 threadActive;
  // end beats an exception raised in the same command write
  assign doExc = cmdWrite && hwdata[`EOF_CMD_EXC] && threadActive && !doEnd;

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      unitSync1_reg <= 4'h0;
      unitSync2_reg <= 4'h0;
      unit_reg <= 4'h0;
    end else begin
      // strap is a pin: two flops first; it is static, so its bits cannot tear
      unitSync1_reg <= unitLocation;
      unitSync2_reg <= unitSync1_reg;
      unit_reg <= unitSync2_reg;
    end
  end

  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      threadActive <= 1'b0;
      threadEnded <= 1'b0;
      slot_reg <= 2'h0;
      ip_reg <= 32'h0000_0000;
      savedIp_reg <= 32'h0000_0000;
      jumpValid <= 1'b0;
      jumpTarget <= 32'h0000_0000;
      excSeen_reg <= 1'b0;
    end else begin
      threadEnded <= 1'b0;
      jumpValid <= 1'b0;
      if (clrStatus && hwdata[`EOF_ST_EXC]) begin
        excSeen_reg <= 1'b0;
      end
      if (doDispatch) begin
        threadActive <= 1'b1;
        slot_reg <= hwdata[`EOF_CMD_SLOT_LSB +: 2];
        ip_reg <= 32'h0000_0000;
      end else if (doEnd) begin
        threadActive <= 1'b0;
        threadEnded <= 1'b1;
      end else if (doExc) begin
        // bookkeeping first: the interrupted pointer is kept
        savedIp_reg <= ip_reg;
        ip_reg <= exceptionHandlerPointer;
        jumpTarget <= exceptionHandlerPointer;
        jumpValid <= 1'b1;
        excSeen_reg <= 1'b1;
      end else if (instrRetire && threadActive) begin
        ip_reg <= ip_reg + `EOF_INSTR_BYTES;
      end
    end
  end
endmodule

/* File: eof_top_assertions.sv */
// port-level assertions for eof_top
// assumes one ahb-lite slave, so hready follows hreadyout
`timescale 1ns/1ps
module eof_top_chk (
  input wire ref_clk,
  input wire resetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire [31:0] hwdata,
  input wire [31:0] exceptionHandlerPointer,
  input wire accessOk,
  input wire accessErr,
  input wire [31:0] checkedAddr,
  input wire threadActive,
  input wire threadEnded,
  input wire jumpValid,
  input wire [31:0] jumpTarget
);
  logic wrPend;
  logic [7:0] wrAddr;
  logic [15:0] ctlShadow;
  logic [2:0] sizeLog;
  logic [31:0] expAddr;
  logic expErr;
  wire goNow = wrPend && wrAddr == 8'h04;
  wire cmd = wrPend && wrAddr == 8'h38;
  wire excReq = cmd && hwdata[3] && threadActive && !(hwdata[1] && hwdata[2]);
  wire endReq = cmd && hwdata[1] && hwdata[2] && threadActive;
  wire typeKnown = ctlShadow[3:0] != 4'h7 && ctlShadow[3:0] < 4'hb;
  //////////////////////////////////////////////////
  // shadow of the control word, so the verdict is predicted independently
  always @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      wrPend <= 1'b0;
      wrAddr <= 8'h00;
      ctlShadow <= 16'h0000;
    end else begin
      wrPend <= hsel & hready & htrans[1] & hwrite;
      wrAddr <= haddr[7:0];
      if (wrPend && wrAddr == 8'h00) begin
        ctlShadow <= hwdata[15:0];
      end
    end
  end
  always_comb begin
    case (ctlShadow[3:0])
      4'h2, 4'h3: sizeLog = 3'd1;
      4'h0, 4'h1, 4'h6: sizeLog = 3'd2;
      4'h8: sizeLog = 3'd3;
      4'h9: sizeLog = 3'd4;
      4'ha: sizeLog = 3'd5;
      default: sizeLog = 3'd0;
    endcase
    expAddr = hwdata + ({24'h0, ctlShadow[15:8]} << sizeLog);
    expErr = (expAddr & ((32'h1 << sizeLog) - 32'h1)) != 32'h0 || !typeKnown;
  end
  //////////////////////////////////////////////////
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  sequence sCheckGo;
    goNow;
  endsequence
  sequence sVerdict;
    ##2 (accessOk != accessErr);
  endsequence
  chk_check_answer: assert property (sCheckGo |-> sVerdict)
    else $error("no single verdict two cycles after base write");
  chk_align_verdict: assert property (sCheckGo |-> ##2 (accessErr == $past(expErr, 2)))
    else $error("alignment verdict wrong");
  chk_checked_addr: assert property (goNow && typeKnown |-> ##2 (checkedAddr == $past(expAddr, 2)))
    else $error("checked address wrong");
  chk_pulse_cause: assert property ((accessOk || accessErr) |-> $past(goNow, 2))
    else $error("verdict pulse without a check");
  chk_exc_jump: assert property (excReq |=> jumpValid && jumpTarget == $past(exceptionHandlerPointer))
    else $error("exception did not jump to shared pointer");
  chk_jump_cause: assert property (jumpValid |-> $past(excReq))
    else $error("jump without exception");
  chk_thread_end: assert property (endReq |=> threadEnded && !threadActive)
    else $error("send with end flag did not end thread");
  chk_dispatch_start: assert property (cmd && hwdata[0] && !threadActive |=> threadActive)
    else $error("dispatch did not start thread");
endmodule
bind eof_top eof_top_chk i_eof_top_chk (.ref_clk(ref_clk), .resetn(resetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
  .exceptionHandlerPointer(exceptionHandlerPointer), .accessOk(accessOk),
  .accessErr(accessErr), .checkedAddr(checkedAddr), .threadActive(threadActive),
  .threadEnded(threadEnded), .jumpValid(jumpValid), .jumpTarget(jumpTarget));

/* File: test_eof_top.sv */
// self-checking bench for eof_top
// assumes a zero-wait slave; the bench is the only ahb-lite master
`timescale 1ns/1ps
module test_eof_top;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [3:0] unitLocation = 4'h9;
  logic [7:0] dispatcherMask = 8'ha5;
  logic [31:0] exceptionHandlerPointer = 32'h1230;
  logic instrRetire = 1'b0;
  wire hreadyout, hresp, accessOk, accessErr, threadActive, threadEnded, jumpValid;
  wire [31:0] hrdata, checkedAddr, jumpTarget;
  logic [31:0] rd;
  logic [31:0] immVal = 32'h7f80_10c3;
  int fails = 0;
  int totalChecks = 0;
  // row: type, expected error, base; element index is always 1
  logic [15:0] rows [15] = '{16'h4001, 16'h5003, 16'h2000, 16'h3101, 16'h0004, 16'h1102,
    16'h600c, 16'h8008, 16'h810c, 16'h9010, 16'h9108, 16'ha020, 16'ha130, 16'h7100, 16'hb100};
  always #5 ref_clk = ~ref_clk;
  eof_top i_eof_top (.ref_clk(ref_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .unitLocation(unitLocation),
    .dispatcherMask(dispatcherMask), .exceptionHandlerPointer(exceptionHandlerPointer),
    .instrRetire(instrRetire), .accessOk(accessOk), .accessErr(accessErr),
    .checkedAddr(checkedAddr), .threadActive(threadActive), .threadEnded(threadEnded),
    .jumpValid(jumpValid), .jumpTarget(jumpTarget));
  //////////////////////////////////////////////////
  task automatic finishTest();
    $display("checks %0d mismatches %0d", totalChecks, fails);
    if (fails == 0 && totalChecks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t got %h exp %h", $time, got, exp);
      fails++;
    end
  endtask
  task automatic waitRdy();
    int n;
    n = 0;
    @(posedge ref_clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 20) begin
        fails++;
        finishTest();
      end
      @(posedge ref_clk);
    end
  endtask
  // whole-word single transfer; read data lands in rd
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {24'h0, a};
    waitRdy();
    htrans <= 2'h0;
    hwdata <= d;
    waitRdy();
    rd = hrdata;
  endtask
  function automatic logic [15:0] sx(input logic [3:0] n);
    return {{12{n[3]}}, n};
  endfunction
  function automatic logic [31:0] tf(input logic [7:0] b);
    if (b[6:0] == 7'h0) begin
      return {b[7], 31'h0};
    end
    return {b[7], {5'h0, b[6:4]} + 8'd124, b[3:0], 19'h0};
  endfunction
  function automatic logic [31:0] slv(input logic [3:0] t);
    case (t)
      4'h2, 4'h3: return 32'h2;
      4'h0, 4'h1, 4'h6: return 32'h4;
      4'h8: return 32'h8;
      4'h9: return 32'h10;
      4'ha: return 32'h20;
      default: return 32'h1;
    endcase
  endfunction
  //////////////////////////////////////////////////
  initial begin
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    bus(0, 8'h08, 32'h0);
    chk(rd, 32'h0);
    chk(hresp, 32'h0);
    bus(0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    $display("reset test done");
    foreach (rows[i]) begin
      bus(1, 8'h00, {16'h0, 8'h01, 4'h0, rows[i][15:12]});
      bus(1, 8'h04, {24'h0, rows[i][7:0]});
      // verdict is read at the edge after the one that launches it
      for (int n = 0; n < 4 && accessOk !== 1'b1 && accessErr !== 1'b1; n++) begin
        @(posedge ref_clk);
      end
      if (accessOk !== 1'b1 && accessErr !== 1'b1) begin
        fails++;
        finishTest();
      end
      chk(accessErr, rows[i][8]);
      chk(accessOk, !rows[i][8]);
      if (rows[i][15:12] != 4'h7 && rows[i][15:12] < 4'hb) begin
        chk(checkedAddr, rows[i][7:0] + slv(rows[i][15:12]));
      end
      bus(0, 8'h08, 32'h0);
      chk(rd[2], !rows[i][8]);
    end
    chk(rd[1:0], 2'b11);
    bus(1, 8'h08, 32'h13);
    bus(0, 8'h08, 32'h0);
    chk(rd, 32'h0);
    $display("alignment test done");
    bus(1, 8'h0c, immVal);
    for (int i = 0; i < 4; i++) begin
      bus(0, 8'(8'h10 + 4 * i), 32'h0);
      chk(rd, {sx(immVal[8 * i + 4 +: 4]), sx(immVal[8 * i +: 4])});
      bus(0, 8'(8'h20 + 4 * i), 32'h0);
      chk(rd, tf(immVal[8 * i +: 8]));
    end
    $display("vector test done");
    bus(0, 8'h30, 32'h0);
    chk(rd, 32'h0000_a524);
    bus(1, 8'h38, 32'h31);
    @(posedge ref_clk);
    chk(threadActive, 32'h1);
    bus(1, 8'h30, 32'hffff_ffff);
    bus(0, 8'h30, 32'h0);
    chk(rd, 32'h0000_a527);
    @(posedge ref_clk);
    instrRetire <= 1'b1;
    repeat (2) @(posedge ref_clk);
    instrRetire <= 1'b0;
    bus(0, 8'h3c, 32'h0);
    chk(rd, 32'h20);
    bus(1, 8'h38, 32'h8);
    @(posedge ref_clk);
    chk(jumpValid, 32'h1);
    chk(jumpTarget, exceptionHandlerPointer);
    bus(0, 8'h44, 32'h0);
    chk(rd, 32'h20);
    bus(0, 8'h34, 32'h0);
    chk(rd, exceptionHandlerPointer);
    bus(0, 8'h08, 32'h0);
    chk(rd, 32'h18);
    bus(1, 8'h38, 32'h6);
    @(posedge ref_clk);
    chk(threadEnded, 32'h1);
    bus(0, 8'h80, 32'h0);
    chk(rd, 32'h0);
    $display("thread test done");
    bus(1, 8'h38, 32'h21);
    @(posedge ref_clk);
    chk(threadActive, 32'h1);
    resetn <= 1'b0;
    @(posedge ref_clk);
    chk(threadActive, 32'h0);
    chk(jumpTarget, 32'h0);
    resetn <= 1'b1;
    bus(0, 8'h08, 32'h0);
    chk(rd, 32'h0);
    bus(0, 8'h3c, 32'h0);
    chk(rd, 32'h0);
    bus(0, 8'h30, 32'h0);
    chk(rd, 32'h0000_a524);
    $display("second reset test done");
    finishTest();
  end
endmodule
